// File: rtl/hsc_pkg.sv
// constants and state types shared by both ends of the hardware standby link
package hsc_pkg;

    // ==========================================================
    // clock and timing
    localparam int CLK_MHZ            = 40;
    localparam int CLK_HZ             = CLK_MHZ * 1_000_000;
    localparam int LS_CLK_HZ          = 32_768;
    localparam int LS_HALF_CYCLES     = CLK_HZ / (2 * LS_CLK_HZ);
    localparam int OSC_SETTLE_US      = 100;
    localparam int OSC_SETTLE_CYCLES  = OSC_SETTLE_US * CLK_MHZ;
    localparam int WDT_EXIT_CYCLES    = 256;
    localparam int RST_LEAD_CYCLES    = 4;
    localparam int TIMER_CLOCK_OUTPUT_HALF_CYCLES   = 4;
    localparam int CNT_W              = 16;

    // ==========================================================
    // pin levels and sampler layout
    localparam logic PIN_LO           = 1'h0;
    localparam logic PIN_HI           = 1'h1;
    localparam int   SYNC_CA          = 0;
    localparam int   SYNC_RST         = 1;
    localparam int   SYNC_LS          = 2;
    localparam int   SYNC_W           = 3;
    localparam logic [SYNC_W-1:0] SYNC_RESET = 3'h3;

    // ==========================================================
    // device power states
    typedef enum logic [2:0] {
        HSC_RUN      = 3'b000,
        HSC_SLEEP    = 3'b001,
        HSC_SWSTBY   = 3'b010,
        HSC_SWEXIT   = 3'b011,
        HSC_HWSTBY   = 3'b100,
        HSC_OSC      = 3'b101,
        HSC_PORPROC  = 3'b110
    } hsc_dev_state_t;

    // controller sequence states
    typedef enum logic [2:0] {
        HSC_C_IDLE   = 3'b000,
        HSC_C_HOLD   = 3'b001,
        HSC_C_RSTLO  = 3'b010,
        HSC_C_SETTLE = 3'b011,
        HSC_C_DONE   = 3'b100
    } hsc_ctl_state_t;

endpackage

// File: rtl/hsc_link_if.sv
// pin-level link between the power controller and the standby logic
`timescale 1ns/1ps
interface hsc_link_if;
    logic standby_request_pin;
    logic power_on_reset_pin_n;
    logic low_speed_crystal_clock;

    modport dev (
        input standby_request_pin,
        input power_on_reset_pin_n,
        input low_speed_crystal_clock
    );

    modport ctl (
        output standby_request_pin,
        output power_on_reset_pin_n,
        output low_speed_crystal_clock
    );
endinterface

// File: rtl/hsc_device.sv
// device end: hardware standby entry, deferral and power-on wake sequence
//
// Operation
// - request needs two consecutive low samples
// - from software standby go straight to standby
// - ignore interrupts and manual reset in standby
// - timer clock output low, timer stopped
// - finish watchdog exit, resume, then standby
// - leave sleep, resume, then enter standby
// - controller holds request pin low throughout
// - only power-on reset leaves standby
// - request rising under reset starts oscillation
// - controller holds reset until oscillation settles
// - reset release starts power-on reset processing
// - no interrupts or manual reset during standby
// - recognised request starts standby transition
// - only real-time-clock modules keep running
`timescale 1ns/1ps
module hsc_device
    import hsc_pkg::*;
#(
    parameter int WDT_CYCLES = hsc_pkg::WDT_EXIT_CYCLES
) (
    input  wire logic                  clk,
    input  wire logic                  reset,
    hsc_link_if.dev                    link,
    input  wire logic                  enter_sleep,
    input  wire logic                  enter_sw_standby,
    input  wire logic                  irq_req,
    input  wire logic                  manual_reset_req,
    output      logic                  internal_clock_run,
    output      logic                  cpu_run,
    output      logic                  timer_unit_run,
    output      logic                  rtc_run,
    output      logic                  timer_clock_output,
    output      logic                  hw_standby,
    output      logic                  osc_on,
    output      logic                  por_start,
    output      hsc_pkg::hsc_dev_state_t mode
);
    import hsc_pkg::*;

    // ==========================================================
    // pin synchronisers
    logic [SYNC_W-1:0]  sync1_ff;
    logic [SYNC_W-1:0]  sync2_ff;
    logic [SYNC_W-1:0]  pins;

    assign pins = {link.low_speed_crystal_clock, link.power_on_reset_pin_n,
                   link.standby_request_pin};

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sync1_ff <= SYNC_RESET;
            sync2_ff <= SYNC_RESET;
        end else begin
            sync1_ff <= pins;
            sync2_ff <= sync1_ff;
        end
    end

    logic ca_s;
    logic rst_n_s;
    logic ls_s;

    assign ca_s    = sync2_ff[SYNC_CA];
    assign rst_n_s = sync2_ff[SYNC_RST];
    assign ls_s    = sync2_ff[SYNC_LS];

    // ==========================================================
    // request sampler on the low-speed clock
    logic        ls_prev_ff;
    logic        nxt_ls_prev;
    logic        ca_last_ff;
    logic        nxt_ca_last;
    logic        pend_ff;
    logic        nxt_pend;
    logic        ls_rise;
    logic        req_seen;
    logic        pend_clear;

    always_comb begin
        ls_rise     = ls_s & ~ls_prev_ff;
        nxt_ls_prev = ls_s;
        nxt_ca_last = ca_last_ff;
        req_seen    = 1'h0;
        if (ls_rise) begin
            nxt_ca_last = ca_s;
            // the previous sample and this one both low
            req_seen    = (ca_last_ff == PIN_LO) && (ca_s == PIN_LO);
        end
        // set wins over clear so a late sample is never lost
        nxt_pend = pend_ff;
        if (pend_clear) begin
            nxt_pend = 1'h0;
        end
        if (req_seen) begin
            nxt_pend = 1'h1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ls_prev_ff <= 1'h1;
            ca_last_ff <= PIN_HI;
            pend_ff    <= 1'h0;
        end else begin
            ls_prev_ff <= nxt_ls_prev;
            ca_last_ff <= nxt_ca_last;
            pend_ff    <= nxt_pend;
        end
    end

    // ==========================================================
    // power state machine
    hsc_dev_state_t     state_ff;
    hsc_dev_state_t     nxt_state;
    logic [CNT_W-1:0]   wdt_ff;
    logic [CNT_W-1:0]   nxt_wdt;
    logic               pend_now;

    assign pend_now = pend_ff | req_seen;

    always_comb begin
        nxt_state  = state_ff;
        nxt_wdt    = wdt_ff;
        pend_clear = 1'h0;
        case (state_ff)
            HSC_RUN: begin
                if (rst_n_s == PIN_LO) begin
                    nxt_state = HSC_OSC;
                end else if (pend_now) begin
                    nxt_state = HSC_HWSTBY;
                end else if (enter_sw_standby) begin
                    nxt_state = HSC_SWSTBY;
                end else if (enter_sleep) begin
                    nxt_state = HSC_SLEEP;
                end
            end
            HSC_SLEEP: begin
                if (rst_n_s == PIN_LO) begin
                    nxt_state = HSC_OSC;
                end else if (pend_now || irq_req || manual_reset_req) begin
                    // resume first; standby is taken from run
                    nxt_state = HSC_RUN;
                end
            end
            HSC_SWSTBY: begin
                if (rst_n_s == PIN_LO) begin
                    nxt_state = HSC_OSC;
                end else if (pend_now) begin
                    nxt_state = HSC_HWSTBY;
                end else if (manual_reset_req) begin
                    nxt_state = HSC_RUN;
                end else if (irq_req) begin
                    nxt_state = HSC_SWEXIT;
                    nxt_wdt   = CNT_W'(WDT_CYCLES - 1);
                end
            end
            HSC_SWEXIT: begin
                // the exit completes unless reset goes low; a request only waits
                if (rst_n_s == PIN_LO) begin
                    nxt_state = HSC_OSC;
                end else if (wdt_ff == '0) begin
                    nxt_state = HSC_RUN;
                end else begin
                    nxt_wdt = wdt_ff - CNT_W'(1);
                end
            end
            HSC_HWSTBY: begin
                pend_clear = 1'h1;
                // interrupts and manual reset are not looked at here
                if ((rst_n_s == PIN_LO) && (ca_s == PIN_HI)) begin
                    nxt_state = HSC_OSC;
                end
            end
            HSC_OSC: begin
                pend_clear = 1'h1;
                if (rst_n_s == PIN_HI) begin
                    nxt_state = HSC_PORPROC;
                end
            end
            HSC_PORPROC: begin
                pend_clear = 1'h1;
                nxt_state  = HSC_RUN;
            end
            default: begin
                nxt_state = HSC_RUN;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_ff <= HSC_PORPROC;
            wdt_ff   <= '0;
        end else begin
            state_ff <= nxt_state;
            wdt_ff   <= nxt_wdt;
        end
    end

    // ==========================================================
    // registered outputs, decoded from the next state
    logic               clk_run_ff;
    logic               nxt_clk_run;
    logic               cpu_run_ff;
    logic               nxt_cpu_run;
    logic               tmu_run_ff;
    logic               nxt_tmu_run;
    logic               timer_clock_output_ff;
    logic               nxt_timer_clock_output;
    logic [CNT_W-1:0]   tdiv_ff;
    logic [CNT_W-1:0]   nxt_tdiv;
    logic               hw_ff;
    logic               nxt_hw;
    logic               osc_ff;
    logic               nxt_osc;
    logic               por_ff;
    logic               nxt_por;

    always_comb begin
        nxt_clk_run = (nxt_state == HSC_RUN) || (nxt_state == HSC_SLEEP)
                      || (nxt_state == HSC_PORPROC);
        nxt_cpu_run = (nxt_state == HSC_RUN);
        nxt_hw      = (nxt_state == HSC_HWSTBY);
        nxt_tmu_run = !nxt_hw && (nxt_state != HSC_OSC);
        nxt_osc     = (nxt_state != HSC_HWSTBY) && (nxt_state != HSC_SWSTBY);
        nxt_por     = (nxt_state == HSC_PORPROC) && (state_ff == HSC_OSC);
        nxt_tdiv    = tdiv_ff;
        nxt_timer_clock_output    = timer_clock_output_ff;
        if (!nxt_tmu_run) begin
            nxt_tdiv = '0;
            nxt_timer_clock_output = 1'h0;
        end else if (tdiv_ff == CNT_W'(TIMER_CLOCK_OUTPUT_HALF_CYCLES - 1)) begin
            nxt_tdiv = '0;
            nxt_timer_clock_output = ~timer_clock_output_ff;
        end else begin
            nxt_tdiv = tdiv_ff + CNT_W'(1);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            clk_run_ff <= 1'h0;
            cpu_run_ff <= 1'h0;
            tmu_run_ff <= 1'h0;
            timer_clock_output_ff    <= 1'h0;
            tdiv_ff    <= '0;
            hw_ff      <= 1'h0;
            osc_ff     <= 1'h1;
            por_ff     <= 1'h0;
        end else begin
            clk_run_ff <= nxt_clk_run;
            cpu_run_ff <= nxt_cpu_run;
            tmu_run_ff <= nxt_tmu_run;
            timer_clock_output_ff    <= nxt_timer_clock_output;
            tdiv_ff    <= nxt_tdiv;
            hw_ff      <= nxt_hw;
            osc_ff     <= nxt_osc;
            por_ff     <= nxt_por;
        end
    end

    // the real-time-clock domain is never stopped by this block
    logic rtc_ff;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rtc_ff <= 1'h0;
        end else begin
            rtc_ff <= 1'h1;
        end
    end

    assign internal_clock_run = clk_run_ff;
    assign cpu_run            = cpu_run_ff;
    assign timer_unit_run     = tmu_run_ff;
    assign rtc_run            = rtc_ff;
    assign timer_clock_output = timer_clock_output_ff;
    assign hw_standby         = hw_ff;
    assign osc_on             = osc_ff;
    assign por_start          = por_ff;
    assign mode               = state_ff;

endmodule // hsc_device

// File: rtl/hsc_controller.sv
// controller end: drives the request and reset pins and the low-speed clock
`timescale 1ns/1ps
module hsc_controller
    import hsc_pkg::*;
#(
    parameter int SETTLE_CYCLES = hsc_pkg::OSC_SETTLE_CYCLES
) (
    input  wire logic   clk,
    input  wire logic   reset,
    hsc_link_if.ctl     link,
    input  wire logic   standby_cmd,
    input  wire logic   wake_cmd,
    output      logic   standby_active,
    output      logic   wake_busy,
    output      logic   wake_done
);
    import hsc_pkg::*;

    // ==========================================================
    // low-speed clock divider
    logic [CNT_W-1:0]   ls_cnt_ff;
    logic [CNT_W-1:0]   nxt_ls_cnt;
    logic               ls_ff;
    logic               nxt_ls;

    always_comb begin
        nxt_ls     = ls_ff;
        nxt_ls_cnt = ls_cnt_ff + CNT_W'(1);
        if (ls_cnt_ff == CNT_W'(LS_HALF_CYCLES - 1)) begin
            nxt_ls_cnt = '0;
            nxt_ls     = ~ls_ff;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ls_cnt_ff <= '0;
            ls_ff     <= 1'h0;
        end else begin
            ls_cnt_ff <= nxt_ls_cnt;
            ls_ff     <= nxt_ls;
        end
    end

    // ==========================================================
    // standby and wake sequence
    hsc_ctl_state_t     state_ff;
    hsc_ctl_state_t     nxt_state;
    logic [CNT_W-1:0]   cnt_ff;
    logic [CNT_W-1:0]   nxt_cnt;
    logic               ca_ff;
    logic               nxt_ca;
    logic               rst_n_ff;
    logic               nxt_rst_n;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        case (state_ff)
            HSC_C_IDLE: begin
                if (standby_cmd) begin
                    nxt_state = HSC_C_HOLD;
                end
            end
            HSC_C_HOLD: begin
                if (wake_cmd) begin
                    nxt_state = HSC_C_RSTLO;
                    nxt_cnt   = CNT_W'(RST_LEAD_CYCLES - 1);
                end
            end
            HSC_C_RSTLO: begin
                // reset goes low first so the request edge is seen under it
                if (cnt_ff == '0) begin
                    nxt_state = HSC_C_SETTLE;
                    nxt_cnt   = CNT_W'(SETTLE_CYCLES - 1);
                end else begin
                    nxt_cnt = cnt_ff - CNT_W'(1);
                end
            end
            HSC_C_SETTLE: begin
                if (cnt_ff == '0) begin
                    nxt_state = HSC_C_DONE;
                end else begin
                    nxt_cnt = cnt_ff - CNT_W'(1);
                end
            end
            HSC_C_DONE: begin
                nxt_state = HSC_C_IDLE;
            end
            default: begin
                nxt_state = HSC_C_IDLE;
            end
        endcase
        // request low through hold and the reset lead; high in every other state
        nxt_ca    = ((nxt_state == HSC_C_HOLD) || (nxt_state == HSC_C_RSTLO))
                    ? PIN_LO : PIN_HI;
        nxt_rst_n = ((nxt_state == HSC_C_RSTLO) || (nxt_state == HSC_C_SETTLE))
                    ? PIN_LO : PIN_HI;
    end

    logic done_ff;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_ff <= HSC_C_IDLE;
            cnt_ff   <= '0;
            ca_ff    <= PIN_HI;
            rst_n_ff <= PIN_HI;
            done_ff  <= 1'h0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            ca_ff    <= nxt_ca;
            rst_n_ff <= nxt_rst_n;
            done_ff  <= (nxt_state == HSC_C_DONE);
        end
    end

    logic active_ff;
    logic busy_ff;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            active_ff <= 1'h0;
            busy_ff   <= 1'h0;
        end else begin
            active_ff <= (nxt_state == HSC_C_HOLD);
            busy_ff   <= (nxt_state == HSC_C_RSTLO) || (nxt_state == HSC_C_SETTLE);
        end
    end

    assign link.standby_request_pin     = ca_ff;
    assign link.power_on_reset_pin_n    = rst_n_ff;
    assign link.low_speed_crystal_clock = ls_ff;
    assign standby_active               = active_ff;
    assign wake_busy                    = busy_ff;
    assign wake_done                    = done_ff;

endmodule // hsc_controller

// File: sim/hsc_link_properties.sv
// pin-level properties of the hardware standby link
`timescale 1ns/1ps
module hsc_link_properties
    import hsc_pkg::*;
#(
    parameter int SETTLE_CYCLES = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic standby_request_pin,
    input wire logic power_on_reset_pin_n,
    input wire logic low_speed_crystal_clock
);
    // ==========================================================
    // helper counters
    logic [CNT_W-1:0] ls_cnt_ff;
    logic [CNT_W-1:0] nxt_ls_cnt;
    logic [CNT_W-1:0] lo_cnt_ff;
    logic [CNT_W-1:0] nxt_lo_cnt;
    logic             ls_prev_ff;
    logic             ls_edge;

    always_comb begin
        ls_edge    = low_speed_crystal_clock != ls_prev_ff;
        nxt_ls_cnt = ls_edge ? '0 : ls_cnt_ff + 1'b1;
        nxt_lo_cnt = power_on_reset_pin_n ? '0 : lo_cnt_ff + 1'b1;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ls_cnt_ff  <= '0;
            lo_cnt_ff  <= '0;
            ls_prev_ff <= 1'b0;
        end else begin
            ls_cnt_ff  <= nxt_ls_cnt;
            lo_cnt_ff  <= nxt_lo_cnt;
            ls_prev_ff <= low_speed_crystal_clock;
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // first half period after reset may be one clock longer than the rest
    ls_half_exact_a: assert property (ls_edge |->
        ls_cnt_ff inside {[LS_HALF_CYCLES-2:LS_HALF_CYCLES]})
        else $error("low-speed clock toggled early");
    ls_half_max_a: assert property (ls_cnt_ff <= LS_HALF_CYCLES)
        else $error("low-speed clock stalled");
    wake_order_a: assert property ($rose(standby_request_pin) |-> !power_on_reset_pin_n)
        else $error("request released without reset low");
    reset_lead_a: assert property ($rose(standby_request_pin) |->
        $past(power_on_reset_pin_n, 4) == 1'b0)
        else $error("reset lead before request release too short");
    reset_first_a: assert property ($fell(power_on_reset_pin_n) |-> !standby_request_pin)
        else $error("reset asserted with request already high");
    settle_hold_a: assert property ($fell(power_on_reset_pin_n) |->
        !power_on_reset_pin_n [*8])
        else $error("reset released before settle");
    settle_len_a: assert property ($rose(power_on_reset_pin_n) |->
        lo_cnt_ff inside {[SETTLE_CYCLES+3:SETTLE_CYCLES+5]})
        else $error("reset low time wrong");
    req_hold_a: assert property ($fell(standby_request_pin) |->
        !standby_request_pin [*8])
        else $error("request pin glitched high");

    cover property ($fell(standby_request_pin));
    cover property ($rose(standby_request_pin));
    cover property ($rose(power_on_reset_pin_n));
endmodule // hsc_link_properties

// File: sim/tb_top.sv
// self-checking bench joining controller and device ends of the standby link
`timescale 1ns/1ps
module tb_top;
    import hsc_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [5:0] stim = 6'h0;
    logic internal_clock_run, cpu_run, timer_unit_run, rtc_run, timer_clock_output;
    logic hw_standby, osc_on, por_start, standby_active, wake_busy, wake_done;
    hsc_dev_state_t mode;
    hsc_dev_state_t last_mode;
    hsc_dev_state_t exp_q[$];
    int error_cnt = 0;
    int cmp_count = 0;

    always #12.5 clk = ~clk;

    // ==========================================================
    // both ends and the link checker
    hsc_link_if link();
    hsc_controller #(.SETTLE_CYCLES(8)) hsc_controller_inst (.clk(clk), .reset(reset),
        .link(link.ctl), .standby_cmd(stim[4]), .wake_cmd(stim[5]),
        .standby_active(standby_active), .wake_busy(wake_busy), .wake_done(wake_done));
    // long watchdog exit so a request can land while the exit is still counting
    hsc_device #(.WDT_CYCLES(3000)) hsc_device_inst (.clk(clk), .reset(reset),
        .link(link.dev), .enter_sleep(stim[0]), .enter_sw_standby(stim[1]),
        .irq_req(stim[2]), .manual_reset_req(stim[3]),
        .internal_clock_run(internal_clock_run), .cpu_run(cpu_run),
        .timer_unit_run(timer_unit_run), .rtc_run(rtc_run),
        .timer_clock_output(timer_clock_output), .hw_standby(hw_standby),
        .osc_on(osc_on), .por_start(por_start), .mode(mode));
    hsc_link_properties #(.SETTLE_CYCLES(8)) hsc_link_properties_inst (.clk(clk),
        .reset(reset), .standby_request_pin(link.standby_request_pin),
        .power_on_reset_pin_n(link.power_on_reset_pin_n),
        .low_speed_crystal_clock(link.low_speed_crystal_clock));

    // ==========================================================
    // compare and closing tasks
    task automatic check_mode(input hsc_dev_state_t e, input hsc_dev_state_t g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] mode exp=%0d got=%0d", e, g);
        end
    endtask

    task automatic check_bit(input string name, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s exp=%b got=%b", name, e, g);
        end
    endtask

    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ==========================================================
    // monitor: every mode change takes the oldest expected mode
    always @(negedge clk) begin
        if (reset) begin
            last_mode = HSC_PORPROC;
        end else if (mode !== last_mode) begin
            last_mode = mode;
            if (exp_q.size() == 0) begin
                error_cnt++;
                $display("[FAIL] unexpected mode got=%0d", mode);
            end else begin
                check_mode(exp_q.pop_front(), mode);
            end
        end
    end

    // ==========================================================
    // drivers
    task automatic pulse(input int b);
        @(posedge clk);
        stim[b] <= 1'b1;
        @(posedge clk);
        stim[b] <= 1'b0;
    endtask

    task automatic wait_mode(input hsc_dev_state_t m);
        int n;
        n = 0;
        // start off the launching edge so mode is read only once settled
        @(negedge clk);
        while (mode !== m && n < 8000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 8000) begin
            error_cnt++;
            $display("[FAIL] wait mode exp=%0d got=%0d", m, mode);
            complete_run();
        end
    endtask

    // k: 0 from run, 1 software standby, 2 sleep, 3 watchdog exit
    task automatic run_case(input int k);
        case (k)
            1: exp_q.push_back(HSC_SWSTBY);
            2: begin exp_q.push_back(HSC_SLEEP); exp_q.push_back(HSC_RUN); end
            3: begin
                exp_q.push_back(HSC_SWSTBY);
                exp_q.push_back(HSC_SWEXIT);
                exp_q.push_back(HSC_RUN);
            end
            default: ;
        endcase
        exp_q.push_back(HSC_HWSTBY);
        exp_q.push_back(HSC_OSC);
        exp_q.push_back(HSC_PORPROC);
        exp_q.push_back(HSC_RUN);
        if (k == 2) pulse(0);
        if (k == 1 || k == 3) begin
            pulse(1);
            wait_mode(HSC_SWSTBY);
        end
        if (k == 3) begin
            pulse(2);
            wait_mode(HSC_SWEXIT);
        end
        repeat ($urandom_range(1, 40)) @(posedge clk);
        pulse(4);
        wait_mode(HSC_HWSTBY);
        check_bit("standby_active", 1'b1, standby_active);
        check_bit("timer_clock_output", 1'b0, timer_clock_output);
        check_bit("timer_unit_run", 1'b0, timer_unit_run);
        check_bit("cpu_run", 1'b0, cpu_run);
        check_bit("internal_clock_run", 1'b0, internal_clock_run);
        check_bit("rtc_run", 1'b1, rtc_run);
        repeat (4) pulse($urandom_range(0, 3));
        repeat (20) @(negedge clk);
        check_bit("hw_standby", 1'b1, hw_standby);
        check_bit("timer_clock_output", 1'b0, timer_clock_output);
        pulse(5);
        wait_mode(HSC_OSC);
        check_bit("osc_on", 1'b1, osc_on);
        check_bit("wake_busy", 1'b1, wake_busy);
        check_bit("standby_active", 1'b0, standby_active);
        wait_mode(HSC_PORPROC);
        check_bit("por_start", 1'b1, por_start);
        wait_mode(HSC_RUN);
        check_bit("cpu_run", 1'b1, cpu_run);
        check_bit("wake_busy", 1'b0, wake_busy);
        repeat (10) @(posedge clk);
        $display("test %0d done", k);
    endtask

    initial begin
        void'($urandom(32'h5BE7DDE0));
        exp_q.push_back(HSC_RUN);
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
        for (int k = 0; k < 4; k++) run_case(k);
        check_bit("queue_empty", 1'b1, exp_q.size() == 0);
        complete_run();
    end
endmodule // tb_top
